// ==== design/epl_energy_pause_log.sv ====
`timescale 1ns/1ns
`include "epl_defines.svh"
module epl_energy_pause_log #(
  parameter logic [31:0] MS_CYCLES      = `EPL_MS_NS / `EPL_CLK_NS,
  parameter logic [31:0] LED_ON_CYCLES  = `EPL_LED_ON_MS * (`EPL_MS_NS / `EPL_CLK_NS),
  parameter logic [31:0] LED_OFF_CYCLES = `EPL_LED_OFF_MS * (`EPL_MS_NS / `EPL_CLK_NS),
  parameter logic [63:0] HOUR_CYCLES    = `EPL_HOUR_MS * 64'(`EPL_MS_NS / `EPL_CLK_NS),
  parameter logic [31:0] IE_MAX_F32     = 32'h3F800000
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Pins from outside the clock domain
  input  wire logic        FAULT_IN,
  input  wire logic        MANUAL_MODE,
  input  wire logic        MAN_CW,
  input  wire logic        MAN_CCW,
  input  wire logic        BASE_REV_OK,
  input  wire logic        COMM_REV_OK,
  // Phase currents from measurement logic
  input  wire logic [15:0] PHASE_A,
  input  wire logic [15:0] PHASE_B,
  input  wire logic [15:0] PHASE_C,
  // Motor drive outputs
  output logic             RUN_CW,
  output logic             RUN_CCW,
  output logic             BRAKE,
  output logic             FAULT_ACK,
  // Indicators
  output logic             DEVICE_LED,
  output logic             GROUP_FAULT_LED
);
  // Synchroniser stages for the six pins
  logic [5:0]            in_meta;            // First stage, read only by in_sync
  logic [5:0]            in_sync;            // Second stage
  logic                  fault_s, manual_s, mcw_s, mccw_s, supported;
  // Software registers
  logic                  soft_variant;       // Soft-starter variant present
  logic [7:0]            out_img;            // Output process image
  logic [15:0]           ramp_ms;            // Ramp-down duration
  logic [7:0]            meas_id;            // Selected measured value identifier
  logic [31:0]           range_f32;          // Range tag as float
  logic [7:0]            log_ds;             // Selected logbook data set
  logic [4:0]            log_idx;            // Entry index, 0 = newest
  logic [1:0]            cmd_res;            // Last command result
  // Sequencer
  epl_pkg::epl_state_t   st;
  logic [31:0]           ms_div;             // Millisecond prescaler
  logic [16:0]           off_ms;             // Elapsed switch-off time
  logic [16:0]           off_target;         // Latched switch-off time
  logic [31:0]           led_cnt;
  logic [63:0]           hour_div;
  logic [15:0]           hours;              // Operating hours time stamp
  logic                  fault_pend;         // Stored fault
  logic                  log_pend;           // Pause event awaiting its slot
  // Bus decode
  logic                  setup_acc, wr_acc;
  logic                  cmd_wr, push_wr;
  logic [31:0]           rd_mux;
  logic                  rd_ok;
  // Command evaluation
  logic [16:0]           min_pause;
  logic                  start_ok;
  // Logbooks
  logic [31:0]           log_mem [3][21];
  logic [4:0]            log_wp  [3];
  logic [4:0]            log_cnt [3];
  logic                  wr_en;
  logic [1:0]            wr_bk;
  logic [31:0]           wr_data;
  logic [17:0]           cur_sum;
  logic [15:0]           cur_val;

  // Data set number to logbook, used for reading and pushing
  function automatic logic [1:0] ds_book(input logic [7:0] ds);
    if (ds == `EPL_DS_TRIP) begin
      return `EPL_BK_TRIP;
    end else if (ds == `EPL_DS_EVENT) begin
      return `EPL_BK_EVENT;
    end else if (ds == `EPL_DS_ERROR) begin
      return `EPL_BK_ERROR;
    end
    return `EPL_BK_NONE;
  endfunction

  // Ring slot of entry idx counted back from the newest
  function automatic logic [4:0] ring_slot(input logic [4:0] wp, input logic [4:0] idx);
    logic [5:0] s;
    s = {1'b0, wp} + {1'b0, `EPL_LOG_DEPTH} - 6'h01 - {1'b0, idx};
    return (s >= {1'b0, `EPL_LOG_DEPTH}) ? 5'(s - {1'b0, `EPL_LOG_DEPTH}) : s[4:0];
  endfunction

  // Two-stage synchroniser; pins are asynchronous to CLOCK
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      in_meta <= 6'h00;
      in_sync <= 6'h00;
    end else begin
      in_meta <= {COMM_REV_OK, BASE_REV_OK, MAN_CCW, MAN_CW, MANUAL_MODE, FAULT_IN};
      in_sync <= in_meta;
    end
  end
  assign fault_s   = in_sync[0];
  assign manual_s  = in_sync[1];
  assign mcw_s     = in_sync[2];
  assign mccw_s    = in_sync[3];
  assign supported = in_sync[4] & in_sync[5];

  // One wait state: a write lands at the edge with PREADY high
  assign setup_acc = PSEL & PENABLE & ~PREADY;
  assign wr_acc    = PSEL & PENABLE & PREADY & PWRITE;
  assign cmd_wr    = wr_acc && (PADDR == `EPL_A_COMMAND);
  assign push_wr   = wr_acc && (PADDR == `EPL_A_LOG_PUSH);

  // Measured values by identifier
  assign cur_sum = {2'h0, PHASE_A} + {2'h0, PHASE_B} + {2'h0, PHASE_C};
  always_comb begin
    if (meas_id == `EPL_ID_IA) begin
      cur_val = PHASE_A;
    end else if (meas_id == `EPL_ID_IB) begin
      cur_val = PHASE_B;
    end else if (meas_id == `EPL_ID_IC) begin
      cur_val = PHASE_C;
    end else if (meas_id == `EPL_ID_MEAN) begin
      cur_val = 16'(cur_sum / 18'h3);
    end else begin
      cur_val = 16'h0000;
    end
  end

  // Read mux; bus stays served in every state
  always_comb begin
    rd_ok = 1'b1;
    if (PADDR == `EPL_A_CONFIG) begin
      rd_mux = {31'h0, soft_variant};
    end else if (PADDR == `EPL_A_OUTIMG) begin
      rd_mux = {24'h0, out_img};
    end else if (PADDR == `EPL_A_RAMP) begin
      rd_mux = {16'h0, ramp_ms};
    end else if (PADDR == `EPL_A_COMMAND) begin
      rd_mux = {30'h0, cmd_res};
    end else if (PADDR == `EPL_A_STATUS) begin
      // Mode identifier and stored fault stay readable while paused
      rd_mux = {15'h0, DEVICE_LED,
                (st == epl_pkg::EPL_PAUSE) ? `EPL_MODE_PAUSE : `EPL_MODE_READY,
                1'b0, supported, manual_s, fault_pend, cmd_res, st};
    end else if (PADDR == `EPL_A_MEAS_ID) begin
      rd_mux = {24'h0, meas_id};
    end else if (PADDR == `EPL_A_MEAS_VAL) begin
      rd_mux = {`EPL_ACC_DOM, `EPL_ACC_CLS, cur_val};
    end else if (PADDR == `EPL_A_RANGE) begin
      rd_mux = range_f32;
    end else if (PADDR == `EPL_A_LOG_SEL) begin
      rd_mux = {11'h0, (ds_book(log_ds) == `EPL_BK_NONE) ? 5'h00 : log_cnt[ds_book(log_ds)],
                3'h0, log_idx, log_ds};
    end else if (PADDR == `EPL_A_LOG_DATA) begin
      if (ds_book(log_ds) == `EPL_BK_NONE || log_idx >= log_cnt[ds_book(log_ds)]) begin
        rd_mux = 32'h0000_0000;
      end else begin
        rd_mux = log_mem[ds_book(log_ds)][ring_slot(log_wp[ds_book(log_ds)], log_idx)];
      end
    end else if (PADDR == `EPL_A_LOG_PUSH) begin
      rd_mux = 32'h0000_0000;
    end else if (PADDR == `EPL_A_TIMING) begin
      rd_mux = {`EPL_TON_MS, `EPL_DWELL_MS, 16'(off_target)};
    end else if (PADDR == `EPL_A_HOURS) begin
      rd_mux = {16'h0, hours};
    end else begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b0;
    end
  end

  // APB answer registers; unmapped addresses give PSLVERR
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup_acc;
      PSLVERR <= setup_acc & ~rd_ok;
      if (setup_acc && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      soft_variant <= 1'b0;
      out_img      <= 8'h00;
      ramp_ms      <= 16'h0000;
      meas_id      <= 8'h00;
      range_f32    <= IE_MAX_F32;
      log_ds       <= 8'h00;
      log_idx      <= 5'h00;
    end else if (wr_acc) begin
      if (PADDR == `EPL_A_CONFIG) begin
        soft_variant <= PWDATA[0];
      end else if (PADDR == `EPL_A_OUTIMG) begin
        out_img <= PWDATA[7:0];
      end else if (PADDR == `EPL_A_RAMP) begin
        ramp_ms <= PWDATA[15:0];
      end else if (PADDR == `EPL_A_MEAS_ID) begin
        meas_id <= PWDATA[7:0];
      end else if (PADDR == `EPL_A_RANGE) begin
        range_f32 <= PWDATA;
      end else if (PADDR == `EPL_A_LOG_SEL) begin
        log_ds  <= PWDATA[7:0];
        log_idx <= PWDATA[12:8];
      end
    end
  end

  // Minimum pause includes the ramp on a soft starter
  assign min_pause = `EPL_BASE_OFF_MS + (soft_variant ? {1'b0, ramp_ms} : 17'h0);
  assign start_ok  = {1'b0, PWDATA[31:16]} >= min_pause;

  // Pause sequencer and command result
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st         <= epl_pkg::EPL_RUN;
      cmd_res    <= `EPL_RES_NONE;
      off_target <= `EPL_BASE_OFF_MS;
    end else if (cmd_wr && (PWDATA[`EPL_C_START] || PWDATA[`EPL_C_END])) begin
      if (!supported || manual_s) begin
        cmd_res <= `EPL_RES_NAK;
      end else if (PWDATA[`EPL_C_END]) begin
        st      <= epl_pkg::EPL_RUN;
        cmd_res <= `EPL_RES_ACK;
      end else if (st != epl_pkg::EPL_RUN) begin
        cmd_res <= `EPL_RES_ACK;
      end else if (start_ok) begin
        // Ramp counts only if the soft starter is switched on now
        off_target <= `EPL_BASE_OFF_MS +
                      ((soft_variant && (RUN_CW || RUN_CCW)) ? {1'b0, ramp_ms} : 17'h0);
        st         <= epl_pkg::EPL_SWOFF;
        cmd_res    <= `EPL_RES_ACK;
      end else begin
        cmd_res <= `EPL_RES_NAK;
      end
    end else if (st == epl_pkg::EPL_SWOFF && off_ms >= off_target) begin
      st <= epl_pkg::EPL_PAUSE;
    end
  end

  // Switch-off timer in milliseconds, restarted on every start from run
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ms_div <= 32'h0;
      off_ms <= 17'h0;
    end else if (st != epl_pkg::EPL_SWOFF) begin
      ms_div <= 32'h0;
      off_ms <= 17'h0;
    end else if (ms_div >= MS_CYCLES - 32'h1) begin
      ms_div <= 32'h0;
      off_ms <= off_ms + 17'h1;
    end else begin
      ms_div <= ms_div + 32'h1;
    end
  end

  // Operating hours counter for time stamps
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      hour_div <= 64'h0;
      hours    <= 16'h0;
    end else if (hour_div >= HOUR_CYCLES - 64'h1) begin
      hour_div <= 64'h0;
      hours    <= hours + 16'h1;
    end else begin
      hour_div <= hour_div + 64'h1;
    end
  end

  // Stored fault: pause never clears it, only acknowledge with fault gone
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      fault_pend <= 1'b0;
    end else if (fault_s) begin
      fault_pend <= 1'b1;
    end else if (out_img[`EPL_B_ACK] && !manual_s) begin
      fault_pend <= 1'b0;
    end
  end

  // Drive outputs; masking only in auto mode, manual keypad always wins
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RUN_CW          <= 1'b0;
      RUN_CCW         <= 1'b0;
      BRAKE           <= 1'b0;
      FAULT_ACK       <= 1'b0;
      GROUP_FAULT_LED <= 1'b0;
    end else begin
      GROUP_FAULT_LED <= fault_pend;
      if (manual_s) begin
        RUN_CW    <= mcw_s & ~mccw_s;
        RUN_CCW   <= mccw_s & ~mcw_s;
        BRAKE     <= mcw_s ^ mccw_s;
        FAULT_ACK <= 1'b0;
      end else begin
        RUN_CW    <= out_img[`EPL_B_CW] & (st == epl_pkg::EPL_RUN);
        RUN_CCW   <= out_img[`EPL_B_CCW] & (st == epl_pkg::EPL_RUN);
        BRAKE     <= out_img[`EPL_B_BRAKE] & (st == epl_pkg::EPL_RUN);
        FAULT_ACK <= out_img[`EPL_B_ACK];
      end
    end
  end

  // Device LED: steady on when ready, distinct blink when paused
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      led_cnt    <= 32'h0;
      DEVICE_LED <= 1'b0;
    end else if (st != epl_pkg::EPL_PAUSE) begin
      led_cnt    <= 32'h0;
      DEVICE_LED <= 1'b1;
    end else if (led_cnt >= LED_ON_CYCLES + LED_OFF_CYCLES - 32'h1) begin
      led_cnt    <= 32'h0;
      DEVICE_LED <= 1'b1;
    end else begin
      led_cnt    <= led_cnt + 32'h1;
      DEVICE_LED <= (led_cnt + 32'h1) < LED_ON_CYCLES;
    end
  end

  // Pause event waits one cycle if software pushes at the same time
  // Set only on the edge at which the sequencer really enters pause
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      log_pend <= 1'b0;
    end else if (st == epl_pkg::EPL_SWOFF && off_ms >= off_target &&
                 !(cmd_wr && (PWDATA[`EPL_C_START] || PWDATA[`EPL_C_END]))) begin
      log_pend <= 1'b1;
    end else if (!(push_wr && ds_book(PWDATA[7:0]) != `EPL_BK_NONE)) begin
      // Held only while a valid push takes the write slot
      log_pend <= 1'b0;
    end
  end

  // Entry: signed identifier above, hours stamp below
  always_comb begin
    wr_en   = 1'b0;
    wr_bk   = `EPL_BK_EVENT;
    wr_data = {`EPL_EVT_PAUSE, hours};
    if (push_wr && ds_book(PWDATA[7:0]) != `EPL_BK_NONE) begin
      wr_en   = 1'b1;
      wr_bk   = ds_book(PWDATA[7:0]);
      wr_data = {PWDATA[8] ? 16'(-{1'b0, PWDATA[30:16]}) : {1'b0, PWDATA[30:16]}, hours};
    end else if (log_pend) begin
      wr_en = 1'b1;
    end
  end

  // Entry storage, no reset needed for the array
  always_ff @(posedge CLOCK) begin
    if (wr_en) begin
      log_mem[wr_bk][log_wp[wr_bk]] <= wr_data;
    end
  end

  // Per-book ring pointers; a write in a delete cycle leaves one entry, stored at the old write pointer
  genvar g;
  for (g = 0; g < 3; g++) begin : g_book
    logic del;
    assign del = cmd_wr && ((g == `EPL_BK_TRIP && PWDATA[`EPL_C_DELTRIP]) ||
                            (g == `EPL_BK_EVENT && PWDATA[`EPL_C_DELEVT]));
    always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
        log_wp[g]  <= 5'h00;
        log_cnt[g] <= 5'h00;
      end else if (wr_en && wr_bk == 2'(g)) begin
        log_wp[g]  <= del ? 5'h01 :
                      (log_wp[g] == `EPL_LOG_DEPTH - 5'h01) ? 5'h00 : log_wp[g] + 5'h01;
        log_cnt[g] <= del ? 5'h01 :
                      (log_cnt[g] == `EPL_LOG_DEPTH) ? log_cnt[g] : log_cnt[g] + 5'h01;
      end else if (del) begin
        log_wp[g]  <= 5'h00;
        log_cnt[g] <= 5'h00;
      end
    end
  end

  // Checks
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_enter_pause;
    st == epl_pkg::EPL_SWOFF ##1 st == epl_pkg::EPL_PAUSE;
  endsequence
  a_mask_run_bits: assert property ((st != epl_pkg::EPL_RUN && !manual_s)
    |=> (!RUN_CW && !RUN_CCW && !BRAKE)) else $error("run bits not masked");
  a_ack_passes: assert property (!manual_s |=> FAULT_ACK == $past(out_img[`EPL_B_ACK]))
    else $error("fault ack blocked");
  a_off_time: assert property ((st == epl_pkg::EPL_SWOFF && off_ms < off_target &&
    !cmd_wr) |=> st == epl_pkg::EPL_SWOFF) else $error("pause entered early");
  a_short_reject: assert property ((cmd_wr && PWDATA[`EPL_C_START] && !PWDATA[`EPL_C_END] &&
    st == epl_pkg::EPL_RUN && !start_ok) |=> st == epl_pkg::EPL_RUN && cmd_res == `EPL_RES_NAK)
    else $error("short pause accepted");
  a_unsupp_nak: assert property ((cmd_wr && (PWDATA[`EPL_C_START] || PWDATA[`EPL_C_END]) &&
    (!supported || manual_s)) |=> cmd_res == `EPL_RES_NAK && $stable(st))
    else $error("command not refused");
  a_end_unmask: assert property ((cmd_wr && PWDATA[`EPL_C_END] && supported && !manual_s)
    |=> st == epl_pkg::EPL_RUN ##1 (RUN_CW == $past(out_img[`EPL_B_CW])))
    else $error("end did not unmask");
  a_pause_logged: assert property (s_enter_pause |-> ##[0:2] (wr_en && wr_bk ==
    `EPL_BK_EVENT && wr_data[31:16] == `EPL_EVT_PAUSE)) else $error("pause not logged");
  a_fault_kept: assert property ((fault_pend && !out_img[`EPL_B_ACK]) |=> fault_pend ##1
    GROUP_FAULT_LED) else $error("fault lost");
  a_error_keep: assert property (log_cnt[`EPL_BK_ERROR] != 5'h00 |=>
    log_cnt[`EPL_BK_ERROR] != 5'h00) else $error("error book cleared");
  a_led_blink: assert property ((st == epl_pkg::EPL_PAUSE && led_cnt == LED_ON_CYCLES - 32'h1
    && $stable(st)) |=> !DEVICE_LED) else $error("led on too long");
endmodule

// ==== design/epl_defines.svh ====
`ifndef EPL_DEFINES_SVH
`define EPL_DEFINES_SVH
// Register byte offsets
`define EPL_A_CONFIG   8'h00
`define EPL_A_OUTIMG   8'h04
`define EPL_A_RAMP     8'h08
`define EPL_A_COMMAND  8'h0C
`define EPL_A_STATUS   8'h10
`define EPL_A_MEAS_ID  8'h14
`define EPL_A_MEAS_VAL 8'h18
`define EPL_A_RANGE    8'h1C
`define EPL_A_LOG_SEL  8'h20
`define EPL_A_LOG_DATA 8'h24
`define EPL_A_LOG_PUSH 8'h28
`define EPL_A_TIMING   8'h2C
`define EPL_A_HOURS    8'h30
// Output image bit positions
`define EPL_B_CW    0
`define EPL_B_CCW   1
`define EPL_B_BRAKE 2
`define EPL_B_ACK   3
// Command bit positions
`define EPL_C_START   0
`define EPL_C_END     1
`define EPL_C_DELTRIP 2
`define EPL_C_DELEVT  3
// Timing
`define EPL_CLK_NS      32'd40
`define EPL_MS_NS       32'd1000000
`define EPL_BASE_OFF_MS 17'd100
`define EPL_DWELL_MS    8'h00
`define EPL_TON_MS      8'h00
`define EPL_LED_ON_MS   32'd250
`define EPL_LED_OFF_MS  32'd1750
`define EPL_HOUR_MS     64'd3600000
// Mode identifiers
`define EPL_MODE_PAUSE 8'h01
`define EPL_MODE_READY 8'hFF
// Measured value identifiers and tolerance tags
`define EPL_ID_IA   8'h07
`define EPL_ID_IB   8'h08
`define EPL_ID_IC   8'h09
`define EPL_ID_MEAN 8'h21
`define EPL_ACC_DOM 8'h01
`define EPL_ACC_CLS 8'h11
// Logbooks
`define EPL_DS_TRIP  8'h49
`define EPL_DS_EVENT 8'h4B
`define EPL_DS_ERROR 8'h48
`define EPL_BK_TRIP  2'h0
`define EPL_BK_EVENT 2'h1
`define EPL_BK_ERROR 2'h2
`define EPL_BK_NONE  2'h3
`define EPL_LOG_DEPTH 5'h15
`define EPL_EVT_PAUSE 16'h05F0
// Command results
`define EPL_RES_NONE 2'h0
`define EPL_RES_ACK  2'h1
`define EPL_RES_NAK  2'h2
`endif

// ==== design/epl_pkg.sv ====
package epl_pkg;
  // Energy-saving sequencer states
  typedef enum logic [1:0] {
    EPL_RUN   = 2'b00,
    EPL_SWOFF = 2'b01,
    EPL_PAUSE = 2'b10
  } epl_state_t;
endpackage

// ==== tb/epl_ctl_model.sv ====
`timescale 1ns/1ns
// Controller side: issues one APB transfer at a time
module epl_ctl_model (
  // Clock
  input  wire logic        CLOCK,
  // APB request
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic      [7:0]  PADDR,
  output logic      [31:0] PWDATA,
  // APB answer
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR
);
  // Bus idle at time zero
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
  end
  // Setup, then access held until PREADY; ok stays low if it never comes
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= we;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge CLOCK);
      ok = (PREADY === 1'b1);
    end
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Released lines flip so a stale address is never taken as valid
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask
endmodule

// ==== tb/epl_energy_pause_log_tb_top.sv ====
`timescale 1ns/1ns
`include "epl_defines.svh"
module epl_energy_pause_log_tb_top;
  logic        clock, rstn, fault_in, manual_mode, man_cw, man_ccw, base_ok, comm_ok;
  logic [15:0] pa, pb, pc;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        run_cw, run_ccw, brake, fault_ack, led, gf_led;
  logic [4:0]  cnt;
  int          errors, n_compared;
  int          cyc_cnt = 0;
  // Short counts keep the pause sequence within a few hundred cycles
  epl_energy_pause_log #(.MS_CYCLES(4), .LED_ON_CYCLES(2), .LED_OFF_CYCLES(6),
    .HOUR_CYCLES(50)) dut_u (.CLOCK(clock), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FAULT_IN(fault_in),
    .MANUAL_MODE(manual_mode), .MAN_CW(man_cw), .MAN_CCW(man_ccw),
    .BASE_REV_OK(base_ok), .COMM_REV_OK(comm_ok), .PHASE_A(pa), .PHASE_B(pb),
    .PHASE_C(pc), .RUN_CW(run_cw), .RUN_CCW(run_ccw), .BRAKE(brake),
    .FAULT_ACK(fault_ack), .DEVICE_LED(led), .GROUP_FAULT_LED(gf_led));
  epl_ctl_model ctl_u (.CLOCK(clock), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  // 25 MHz clock and a free cycle count for timing figures
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) cyc_cnt <= cyc_cnt + 1;
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One transfer; a slave that never answers ends the run
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    ctl_u.xfer(we, a, d, rd, err, ok);
    if (!ok) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Command result field only
  task automatic res(input logic [1:0] exp);
    bus(1'b0, `EPL_A_COMMAND, 32'h00000000);
    check({30'h0, rd[1:0]}, {30'h0, exp});
  endtask
  // Select a logbook entry: count into cnt, entry into rd
  task automatic sel(input logic [7:0] ds, input logic [4:0] idx);
    wr(`EPL_A_LOG_SEL, {19'h0, idx, ds});
    bus(1'b0, `EPL_A_LOG_SEL, 32'h00000000);
    cnt = rd[20:16];
    bus(1'b0, `EPL_A_LOG_DATA, 32'h00000000);
  endtask
  task automatic t_idle();
    rdchk(`EPL_A_STATUS, 32'h0001FF40);
    bus(1'b0, 8'h34, 32'h00000000);
    check({31'h0, err}, 32'h1);
    rdchk(`EPL_A_RANGE, 32'h3F800000);
  endtask
  task automatic t_meas();
    logic [7:0]  ids [5] = '{8'h07, 8'h08, 8'h09, 8'h21, 8'h0A};
    logic [15:0] val [5] = '{16'h0003, 16'h0005, 16'h0008, 16'h0005, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      wr(`EPL_A_MEAS_ID, {24'h0, ids[i]});
      rdchk(`EPL_A_MEAS_VAL, {8'h01, 8'h11, val[i]});
    end
  endtask
  // Refusals: each revision input, manual mode, too short, ramp added
  task automatic t_refuse();
    base_ok <= 1'b0;
    cyc(3);
    wr(`EPL_A_COMMAND, {16'd200, 16'h0001});
    res(2'h2);
    base_ok <= 1'b1;
    comm_ok <= 1'b0;
    cyc(3);
    wr(`EPL_A_COMMAND, {16'd200, 16'h0001});
    res(2'h2);
    comm_ok <= 1'b1;
    manual_mode <= 1'b1;
    cyc(3);
    wr(`EPL_A_COMMAND, {16'd200, 16'h0001});
    res(2'h2);
    manual_mode <= 1'b0;
    cyc(3);
    wr(`EPL_A_COMMAND, {16'd99, 16'h0001});
    res(2'h2);
    wr(`EPL_A_CONFIG, 32'h1);
    wr(`EPL_A_RAMP, 32'd5);
    wr(`EPL_A_COMMAND, {16'd104, 16'h0001});
    res(2'h2);
  endtask
  // Running soft starter with a stored fault goes into pause and back
  task automatic t_pause();
    int t0;
    int ones;
    fault_in <= 1'b1;
    wr(`EPL_A_OUTIMG, 32'h9);
    cyc(4);
    check({31'h0, gf_led}, 32'h1);
    wr(`EPL_A_COMMAND, {16'd105, 16'h0001});
    t0 = cyc_cnt;
    res(2'h1);
    check({30'h0, run_cw, brake}, 32'h0);
    check({31'h0, fault_ack}, 32'h1);
    rd = 32'h0;
    for (int k = 0; k < 200 && rd[1:0] !== 2'h2; k++) begin
      bus(1'b0, `EPL_A_STATUS, 32'h00000000);
    end
    // A pause that never comes ends the run here
    if (rd[1:0] !== 2'h2) begin
      errors++;
      tally_and_finish();
    end
    check({31'h0, (cyc_cnt - t0 >= 416) && (cyc_cnt - t0 <= 436)}, 32'h1);
    check({24'h0, rd[15:8]}, 32'h1);
    check({31'h0, rd[4]}, 32'h1);
    check({31'h0, gf_led}, 32'h1);
    rdchk(`EPL_A_TIMING, 32'd105);
    ones = 0;
    repeat (16) begin
      @(posedge clock);
      ones += (led === 1'b1);
    end
    check(ones, 32'd4);
    sel(`EPL_DS_EVENT, 5'd0);
    check({16'h0, rd[31:16]}, 32'h05F0);
    rdchk(`EPL_A_RANGE, 32'h3F800000);
    manual_mode <= 1'b1;
    man_ccw <= 1'b1;
    cyc(4);
    check({30'h0, run_ccw, brake}, 32'h3);
    manual_mode <= 1'b0;
    man_ccw <= 1'b0;
    cyc(4);
    wr(`EPL_A_COMMAND, 32'h2);
    cyc(3);
    check({31'h0, run_cw}, 32'h1);
    rdchk(`EPL_A_STATUS, 32'h0001FF54);
    fault_in <= 1'b0;
    cyc(6);
    check({31'h0, gf_led}, 32'h0);
    // Motor already off: switch-off time is the base time alone
    wr(`EPL_A_OUTIMG, 32'h8);
    cyc(2);
    wr(`EPL_A_COMMAND, {16'd105, 16'h0001});
    res(2'h1);
    rdchk(`EPL_A_TIMING, 32'd100);
    wr(`EPL_A_COMMAND, 32'h2);
  endtask
  // Ring overwrite, sign of outgoing entries and deletion
  task automatic t_logs();
    for (int i = 1; i <= 22; i++) begin
      wr(`EPL_A_LOG_PUSH, {1'b0, 15'(i), 8'h00, `EPL_DS_TRIP});
    end
    sel(`EPL_DS_TRIP, 5'd0);
    check({27'h0, cnt}, 32'd21);
    check({16'h0, rd[31:16]}, 32'd22);
    sel(`EPL_DS_TRIP, 5'd20);
    check({16'h0, rd[31:16]}, 32'd2);
    wr(`EPL_A_LOG_PUSH, {1'b0, 15'd7, 8'h01, `EPL_DS_EVENT});
    sel(`EPL_DS_EVENT, 5'd0);
    check({16'h0, rd[31:16]}, 32'hFFF9);
    wr(`EPL_A_LOG_PUSH, {1'b0, 15'd3, 8'h00, `EPL_DS_ERROR});
    wr(`EPL_A_COMMAND, 32'hC);
    sel(`EPL_DS_TRIP, 5'd0);
    check({27'h0, cnt}, 32'd0);
    sel(`EPL_DS_EVENT, 5'd0);
    check({27'h0, cnt}, 32'd0);
    sel(`EPL_DS_ERROR, 5'd0);
    check({27'h0, cnt}, 32'd1);
  endtask
  // Reset for six cycles, then the scenarios in turn
  initial begin
    {rstn, fault_in, manual_mode, man_cw, man_ccw} = 5'h0;
    {base_ok, comm_ok} = 2'h3;
    pa = 16'h0003;
    pb = 16'h0005;
    pc = 16'h0008;
    {errors, n_compared} = 0;
    cyc(6);
    rstn <= 1'b1;
    cyc(3);
    t_idle();
    t_meas();
    t_refuse();
    t_pause();
    t_logs();
    tally_and_finish();
  end
endmodule
